// *** hdl/asop_defines.svh ***
// Constants of the converter serial output port: counts, widths and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ASOP_DEFINES_SVH
`define ASOP_DEFINES_SVH

// Master clock rising edges between two refreshes of the output register.
`define ASOP_REFRESH_CYCLES 1024
// Self-clocked bit clock: half period in nanoseconds, and in system clock cycles.
`define ASOP_SSC_HALF_NS    40
`define ASOP_CLK_NS         10
`define ASOP_SSC_HALF_CYC   ((`ASOP_SSC_HALF_NS + `ASOP_CLK_NS - 1) / `ASOP_CLK_NS)
// Word widths of the two variants and of one asynchronous frame pair.
`define ASOP_WORD_W         20
`define ASOP_NARROW_BITS    16
`define ASOP_WIDE_BITS      20
`define ASOP_AC_BITS        22
`define ASOP_FRAME_W        24
// Buffer depth in words.
`define ASOP_FIFO_DEPTH     32
// Reset values of the serial pins.
`define ASOP_LINE_IDLE      1'b1
`define ASOP_READY_N_RST    1'b1

`endif

// *** hdl/asop_pkg.sv ***
// Types shared by the serial output port and its test bench.
// Assumes the constants header is on the include path.
`include "asop_defines.svh"

package asop_pkg;

  // Output framing, Gray-coded along the pin order.
  typedef enum logic [1:0]
  {
    ASOP_SELF_CLOCKED = 2'h0,
    ASOP_EXT_CLOCKED  = 2'h1,
    ASOP_ASYNC_CHAR   = 2'h3
  } asop_mode_e;

  // Shift sequencer states, Gray-coded.
  typedef enum logic [1:0]
  {
    ASOP_IDLE  = 2'h0,
    ASOP_SHIFT = 2'h1,
    ASOP_DONE  = 2'h3
  } asop_state_e;

  typedef logic [`ASOP_WORD_W-1:0]  asop_word_t;
  typedef logic [`ASOP_FRAME_W-1:0] asop_frame_t;

endpackage

// *** hdl/asop_fifo_if.sv ***
// Valid/ready carrier between the port logic and its word buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface asop_fifo_if #(parameter int WIDTH = 20);
  logic [WIDTH-1:0] in_data;
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] out_data;
  logic             out_valid;
  logic             out_ready;

  modport buffer (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user   (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface

`default_nettype wire

// *** hdl/asop_fifo.sv ***
// Word buffer between conversion refresh and serial readout.
// Assumes one clock and a reset already synchronised.
`timescale 1ns/1ps
`default_nettype none

module asop_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Both sides of the buffer.
  asop_fifo_if.buffer fif
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Full and empty come from the count, so back-pressure is exact.
  assign fif.in_ready  = (count_r != (AW+1)'(DEPTH));
  assign fif.out_valid = (count_r != '0);
  assign fif.out_data  = mem[rd_ptr_r];
  assign push          = fif.in_valid && fif.in_ready;
  assign pop           = fif.out_valid && fif.out_ready;

  // Storage array; written only on an accepted push.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= fif.in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// *** hdl/asop_port.sv ***
// Serial output port of a sigma-delta converter: refresh, buffer, ready flag, framing.
// Assumes clk at 100 MHz; all pins except conv_word are asynchronous to clk.
//
// How it works
// RULE1: Ready goes low when output register refreshes.
// RULE2: Words move out only while select low.
// RULE3: Word appears bit by bit on line.
// RULE4: Mode pins choose framing; variant limits choices.
// RULE5: Self-clocked mode drives bit clock with data.
// RULE6: Other modes take bit clock from reader.
// RULE7: Wide variant lacks asynchronous character mode.
// RULE8: Characters get start bit, two stops.
// RULE9: Self-clocked mode runs on select alone.
// RULE10: Word is twenty or sixteen bits wide.
// RULE11: New word every 1024 master clocks.
// RULE12: Ready falls only after previous word read.
// RULE13: Word goes as two eleven-bit characters.
// RULE14: Most significant first; pins released when deselected.
`timescale 1ns/1ps
`default_nettype none
`include "asop_defines.svh"

module asop_port (
  // System clock and asynchronous reset.
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Converter core side.
  input  wire logic                    master_clock_in,
  input  wire logic [`ASOP_WORD_W-1:0] conv_word,
  output var  logic                    conv_ready,
  // Straps and selects from pins.
  input  wire logic [1:0]              mode_sel,
  input  wire logic                    wide_variant,
  input  wire logic                    select_n,
  // Serial pins: bit clock as in, out and enable; data as out and enable; ready flag out.
  input  wire logic                    serial_clk_in,
  output var  logic                    serial_clk_out,
  output var  logic                    serial_clk_oe,
  output var  logic                    serial_out_line,
  output var  logic                    serial_out_oe,
  output var  logic                    word_ready_n
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Bit reversal, so each character leaves least significant first.
  function automatic logic [7:0] asop_rev8(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Builds the shift image of one word for the chosen framing.
  function automatic asop_pkg::asop_frame_t asop_frame(input asop_pkg::asop_word_t w,
                                                       input asop_pkg::asop_mode_e m,
                                                       input logic wide);
    asop_pkg::asop_frame_t f;
    f = '0;
    if (m == asop_pkg::ASOP_ASYNC_CHAR)
    begin
      f = {1'b0, asop_rev8(w[15:8]), 2'h3, 1'b0, asop_rev8(w[7:0]), 2'h3, 2'h3}; // RULE8 RULE13
    end
    else if (wide)
    begin
      f = {w, 4'h0}; // RULE10 RULE14
    end
    else
    begin
      f = {w[15:0], 8'h00}; // RULE10 RULE14
    end
    return f;
  endfunction

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************

  logic       rst_meta_r;
  logic       rst_n_r;
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  logic       mclk_d_r;
  logic       sclk_d_r;
  logic       serial_clk_s;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Two stages per pin; logic reads the second stage, and for the two clocks also a delayed copy of it.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pin_meta_r <= 6'h10;
      pin_sync_r <= 6'h10;
      mclk_d_r   <= 1'b0;
      sclk_d_r   <= 1'b0;
    end
    else
    begin
      pin_meta_r <= {serial_clk_in, select_n, wide_variant, mode_sel, master_clock_in};
      pin_sync_r <= pin_meta_r;
      mclk_d_r   <= pin_sync_r[0];
      sclk_d_r   <= pin_sync_r[5];
    end
  end

  // The reader's bit clock rides in the top bit of the pin synchroniser.
  assign serial_clk_s = pin_sync_r[5];

  logic                 mclk_rise;
  logic                 ext_rise;
  logic                 ext_fall;
  logic                 sel_low;
  logic                 wide;
  asop_pkg::asop_mode_e mode;

  // The wide variant has no character mode, so that code falls back to external clocking.
  always_comb
  begin
    mclk_rise = pin_sync_r[0] && !mclk_d_r;
    ext_rise  = serial_clk_s && !sclk_d_r; // RULE6
    ext_fall  = !serial_clk_s && sclk_d_r; // RULE6
    sel_low   = !pin_sync_r[4];
    wide      = pin_sync_r[3];
    if (!pin_sync_r[2] && !pin_sync_r[1])
    begin
      mode = asop_pkg::ASOP_SELF_CLOCKED; // RULE4
    end
    else if (!pin_sync_r[2] || wide)
    begin
      mode = asop_pkg::ASOP_EXT_CLOCKED; // RULE4 RULE7
    end
    else
    begin
      mode = asop_pkg::ASOP_ASYNC_CHAR; // RULE4
    end
  end

  // ****************************************************************
  // Refresh timer and word buffer
  // ****************************************************************

  logic [9:0] refresh_cnt_r;
  logic       refresh;

  asop_fifo_if #(.WIDTH(`ASOP_WORD_W)) fif ();

  assign refresh = mclk_rise && (refresh_cnt_r == 10'(`ASOP_REFRESH_CYCLES - 1));

  // One word enters the buffer per refresh period of the master clock.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      refresh_cnt_r <= 10'h000;
      conv_ready    <= 1'b0;
    end
    else
    begin
      if (mclk_rise)
      begin
        refresh_cnt_r <= refresh_cnt_r + 10'h001; // RULE11
      end
      conv_ready <= fif.in_ready;
    end
  end

  // A refresh that meets a full buffer is lost; conv_ready shows that risk.
  assign fif.in_valid = refresh; // RULE11
  assign fif.in_data  = conv_word;

  asop_fifo #(.WIDTH(`ASOP_WORD_W), .DEPTH(`ASOP_FIFO_DEPTH)) u_fifo
  (
    .clk   (clk),
    .rst_n (rst_n_r),
    .fif   (fif)
  );

  // ****************************************************************
  // Output register and ready flag
  // ****************************************************************

  asop_pkg::asop_word_t  out_word_r;
  logic                  out_full_r;
  logic                  word_read;
  asop_pkg::asop_state_e state_r;

  assign fif.out_ready = !out_full_r;

  // The next word waits in the buffer until the last one left the port.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      out_word_r   <= '0;
      out_full_r   <= 1'b0;
      word_ready_n <= `ASOP_READY_N_RST;
    end
    else
    begin
      if (!out_full_r && fif.out_valid)
      begin
        out_word_r   <= fif.out_data;
        out_full_r   <= 1'b1;
        word_ready_n <= 1'b0; // RULE1 RULE12
      end
      else if (word_read)
      begin
        out_full_r   <= 1'b0;
        word_ready_n <= 1'b1; // RULE12
      end
    end
  end

  // ****************************************************************
  // Shift sequencer
  // ****************************************************************

  asop_pkg::asop_frame_t shreg_r;
  asop_pkg::asop_mode_e  run_mode_r;
  logic [4:0]            bit_cnt_r;
  logic [4:0]            total;
  logic [2:0]            div_cnt_r;
  logic                  tick;
  logic                  rise_ev;
  logic                  fall_ev;

  // Self-clocked rate: toggle enable from a divider of the system clock.
  assign tick    = (div_cnt_r == 3'(`ASOP_SSC_HALF_CYC - 1));
  assign rise_ev = (run_mode_r == asop_pkg::ASOP_SELF_CLOCKED) ? (tick && !serial_clk_out)
                                                               : ext_rise; // RULE5 RULE9
  assign fall_ev = (run_mode_r == asop_pkg::ASOP_SELF_CLOCKED) ? (tick && serial_clk_out)
                                                               : ext_fall;
  assign total   = (run_mode_r == asop_pkg::ASOP_ASYNC_CHAR) ? 5'(`ASOP_AC_BITS) :
                   wide ? 5'(`ASOP_WIDE_BITS) : 5'(`ASOP_NARROW_BITS); // RULE10
  assign word_read = (state_r == asop_pkg::ASOP_SHIFT) && sel_low &&
                     (((run_mode_r == asop_pkg::ASOP_ASYNC_CHAR) && rise_ev &&
                       (bit_cnt_r == total - 5'h01)) ||
                      ((run_mode_r != asop_pkg::ASOP_ASYNC_CHAR) && fall_ev &&
                       (bit_cnt_r == total)));

  // Divider runs whenever the sequencer is in ASOP_SHIFT, whatever the framing.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      div_cnt_r <= 3'h0;
    end
    else if (state_r != asop_pkg::ASOP_SHIFT || tick)
    begin
      div_cnt_r <= 3'h0;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // Deselecting mid-word abandons it; the word stays and restarts from its first bit.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r        <= asop_pkg::ASOP_IDLE;
      shreg_r        <= '1;
      run_mode_r     <= asop_pkg::ASOP_SELF_CLOCKED;
      bit_cnt_r      <= 5'h00;
      serial_clk_out <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        asop_pkg::ASOP_IDLE:
        begin
          serial_clk_out <= 1'b0;
          if (sel_low && out_full_r) // RULE2
          begin
            shreg_r    <= asop_frame(out_word_r, mode, wide);
            run_mode_r <= mode;
            bit_cnt_r  <= 5'h00;
            state_r    <= asop_pkg::ASOP_SHIFT;
          end
        end
        asop_pkg::ASOP_SHIFT:
        begin
          if (!sel_low)
          begin
            state_r <= asop_pkg::ASOP_IDLE; // RULE2
          end
          else if (word_read)
          begin
            serial_clk_out <= 1'b0;
            shreg_r        <= '1;
            state_r        <= asop_pkg::ASOP_DONE;
          end
          else if (run_mode_r == asop_pkg::ASOP_ASYNC_CHAR)
          begin
            if (rise_ev)
            begin
              shreg_r   <= {shreg_r[`ASOP_FRAME_W-2:0], 1'b1}; // RULE3 RULE6
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end
          end
          else if (rise_ev)
          begin
            serial_clk_out <= (run_mode_r == asop_pkg::ASOP_SELF_CLOCKED); // RULE5
            bit_cnt_r      <= bit_cnt_r + 5'h01;
          end
          else if (fall_ev)
          begin
            serial_clk_out <= 1'b0;
            shreg_r        <= {shreg_r[`ASOP_FRAME_W-2:0], 1'b1}; // RULE3 RULE14
          end
        end
        asop_pkg::ASOP_DONE:
        begin
          if (!sel_low)
          begin
            state_r <= asop_pkg::ASOP_IDLE;
          end
        end
        default:
        begin
          state_r <= asop_pkg::ASOP_IDLE;
        end
      endcase
    end
  end

  // Pin drivers are registered; pins float whenever select is high.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      serial_out_line <= `ASOP_LINE_IDLE;
      serial_out_oe   <= 1'b0;
      serial_clk_oe   <= 1'b0;
    end
    else
    begin
      serial_out_oe   <= sel_low; // RULE14
      serial_clk_oe   <= sel_low && (mode == asop_pkg::ASOP_SELF_CLOCKED); // RULE5 RULE6
      serial_out_line <= (state_r == asop_pkg::ASOP_SHIFT) ? shreg_r[`ASOP_FRAME_W-1]
                                                           : `ASOP_LINE_IDLE; // RULE3
    end
  end

endmodule

`default_nettype wire

// *** verification/asop_port_assertions.sv ***
// Pin-level checks on the serial output port.
// Assumes a bind to asop_port and the constants header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "asop_defines.svh"

// ****************
// Checker module
// ****************
module asop_port_assertions (
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    reset_n,
  // Converter side.
  input wire logic                    master_clock_in,
  input wire logic [`ASOP_WORD_W-1:0] conv_word,
  input wire logic                    conv_ready,
  // Straps, select and serial pins.
  input wire logic [1:0]              mode_sel,
  input wire logic                    wide_variant,
  input wire logic                    select_n,
  input wire logic                    serial_clk_in,
  input wire logic                    serial_clk_out,
  input wire logic                    serial_clk_oe,
  input wire logic                    serial_out_line,
  input wire logic                    serial_out_oe,
  input wire logic                    word_ready_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Raw select may rise mid-phase, which ends the word early, so it excuses the check.
  sequence s_high_four;
    (serial_clk_out || select_n)[*4] ##1 (!serial_clk_out || select_n);
  endsequence
  sequence s_sel_held;
    $fell(select_n) ##0 (!select_n)[*6];
  endsequence

  a_oe_select: assert property (s_sel_held |-> serial_out_oe)
    else $error("data enable missing while selected");
  a_pins_release: assert property (select_n[*4] |-> !serial_out_oe && !serial_clk_oe)
    else $error("pins driven while deselected");
  a_line_idle: assert property (select_n[*6] |-> serial_out_line && !serial_clk_out)
    else $error("idle levels wrong while deselected");
  a_ext_clk_input: assert property ((mode_sel != 2'h0)[*4] |-> !serial_clk_oe)
    else $error("bit clock driven outside self-clocked mode");
  a_ssc_clk_drive: assert property ((mode_sel == 2'h0 && !select_n)[*5] |-> serial_clk_oe)
    else $error("bit clock not driven in self-clocked mode");
  a_ssc_high: assert property ($rose(serial_clk_out) |-> s_high_four)
    else $error("bit clock high phase not four cycles");
  a_ssc_low: assert property ($fell(serial_clk_out) && !select_n |->
                               (!serial_clk_out || select_n)[*4])
    else $error("bit clock low phase too short");
  a_ssc_stable: assert property (serial_clk_out && !select_n |-> $stable(serial_out_line))
    else $error("data moved while bit clock high");
  a_ready_fall_idle: assert property ($fell(word_ready_n) |-> serial_out_line && !serial_clk_out)
    else $error("new word flagged during a transfer");
  a_ready_after_read: assert property ($rose(word_ready_n) |-> !$past(select_n, 4))
    else $error("word flag cleared without a readout");
endmodule

bind asop_port asop_port_assertions u_chk (.clk, .reset_n, .master_clock_in, .conv_word,
  .conv_ready, .mode_sel, .wide_variant, .select_n, .serial_clk_in, .serial_clk_out,
  .serial_clk_oe, .serial_out_line, .serial_out_oe, .word_ready_n);

`default_nettype wire

// *** verification/asop_reader_model.sv ***
// Behavioural reader on the far side: selects the port and collects one frame.
// Assumes the bench calls frame() from one process at a time.
`timescale 1ns/1ps
`default_nettype none

// ****************
// Reader model
// ****************
module asop_reader_model (
  // Pacing clock.
  input  wire logic clk,
  // Pins toward the port.
  output var  logic select_n,
  output var  logic serial_clk_in,
  input  wire logic serial_clk_out,
  input  wire logic serial_out_line,
  input  wire logic serial_out_oe
);
  logic data_w;

  // A released line has no pull, so it reads inverted; a missing enable can never pass.
  assign data_w = serial_out_oe ? serial_out_line : ~serial_out_line;

  // Both pins rest high and low; the clock stands still between frames.
  initial
  begin
    select_n      = 1'b1;
    serial_clk_in = 1'b0;
  end

  // Collects up to nbits, oldest bit highest; stop_at below nbits abandons the word.
  task automatic frame(input logic self_clk, input int nbits, input int stop_at,
                       output logic [21:0] bits);
    bits = '0;
    @(posedge clk);
    select_n <= 1'b0;
    repeat (self_clk ? 2 : 8) @(posedge clk);
    for (int i = 0; i < nbits && i < stop_at; i++)
    begin
      if (self_clk)
      begin
        @(posedge serial_clk_out);
        bits = {bits[20:0], data_w};
      end
      else
      begin
        // The reader takes each bit on its own rising edge, as a shift register would.
        #62.5 serial_clk_in = 1'b1;
        bits = {bits[20:0], data_w};
        #62.5 serial_clk_in = 1'b0;
      end
    end
    repeat (12) @(posedge clk);
    select_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// *** verification/asop_port_tb.sv ***
// Self-checking bench for the serial output port in all framings.
// Assumes the design files and the reader model are compiled first.
`timescale 1ns/1ps
`default_nettype none

// ****************
// Bench top
// ****************
module asop_port_tb;
  localparam asop_pkg::asop_word_t WORD = 20'h9A3C6;
  logic                 clk;
  logic                 reset_n;
  logic                 master_clock_in;
  asop_pkg::asop_word_t conv_word;
  logic [1:0]           mode_sel;
  logic                 wide_variant;
  logic                 select_n;
  logic                 serial_clk_in;
  logic                 conv_ready;
  logic                 serial_clk_out;
  logic                 serial_clk_oe;
  logic                 serial_out_line;
  logic                 serial_out_oe;
  logic                 word_ready_n;
  logic [21:0]          bits;
  int                   mrise;
  int                   m0;
  int                   fail_count;
  int                   num_checks;

  asop_port dut (.clk, .reset_n, .master_clock_in, .conv_word, .conv_ready, .mode_sel,
    .wide_variant, .select_n, .serial_clk_in, .serial_clk_out, .serial_clk_oe,
    .serial_out_line, .serial_out_oe, .word_ready_n);
  asop_reader_model reader (.clk, .select_n, .serial_clk_in, .serial_clk_out,
    .serial_out_line, .serial_out_oe);

  // Clocks; the master clock runs fast so a full buffer fits in the run.
  always #5 clk = ~clk;
  always @(posedge master_clock_in) mrise <= mrise + 1;
  initial
  begin
    master_clock_in = 1'b0;
    #3;
    forever #10 master_clock_in = ~master_clock_in;
  end

  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi)
    begin
      fail_count++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // Start bit, eight bits low first, two stop bits; high byte goes first.
  function automatic logic [21:0] ac_frame(input logic [15:0] w);
    logic [21:0] e;
    e = '0;
    for (int i = 0; i < 22; i++)
      e[21-i] = (i % 11 == 0) ? 1'b0 : (i % 11 > 8) ? 1'b1 : w[(i < 11 ? 7 : -1) + i % 11];
    return e;
  endfunction

  task automatic cfg(input logic [1:0] m, input logic w);
    @(posedge clk);
    mode_sel     <= m;
    wide_variant <= w;
    repeat (5) @(posedge clk);
  endtask

  // Sampled on the falling edge, where the flag has settled.
  task automatic wait_ready();
    for (int i = 0; i < 2200 && word_ready_n !== 1'b0; i++)
      @(negedge clk);
    check(word_ready_n, 1'b0);
  endtask

  task automatic t_self_narrow();
    cfg(2'h0, 1'b0);
    wait_ready();
    check_range(mrise - m0, 1024, 1029);
    m0 = mrise;
    reader.frame(1'b1, 16, 99, bits);
    check(bits, {6'h00, WORD[15:0]});
    check(word_ready_n, 1'b1);
    wait_ready();
    check_range(mrise - m0, 1023, 1025);
  endtask

  task automatic t_self_wide();
    cfg(2'h0, 1'b1);
    wait_ready();
    reader.frame(1'b1, 20, 99, bits);
    check(bits, {2'h0, WORD});
  endtask

  task automatic t_abort();
    cfg(2'h0, 1'b0);
    wait_ready();
    reader.frame(1'b1, 16, 5, bits);
    check(word_ready_n, 1'b0);
    reader.frame(1'b1, 16, 99, bits);
    check(bits, {6'h00, WORD[15:0]});
  endtask

  task automatic t_ext();
    cfg(2'h1, 1'b1);
    wait_ready();
    reader.frame(1'b0, 20, 99, bits);
    check(bits, {2'h0, WORD});
    cfg(2'h2, 1'b1);
    wait_ready();
    reader.frame(1'b0, 20, 99, bits);
    check(bits, {2'h0, WORD});
  endtask

  task automatic t_async();
    cfg(2'h3, 1'b0);
    wait_ready();
    reader.frame(1'b0, 22, 99, bits);
    check(bits, ac_frame(WORD[15:0]));
  endtask

  // The reader stalls until the buffer refuses, then drains it dry.
  task automatic t_fill();
    int got;
    got = 0;
    cfg(2'h0, 1'b0);
    for (int i = 0; i < 72000 && conv_ready !== 1'b0; i++)
      @(negedge clk);
    check(conv_ready, 1'b0);
    for (int n = 0; n < 40 && word_ready_n === 1'b0; n++)
    begin
      reader.frame(1'b1, 16, 99, bits);
      check(bits, {6'h00, WORD[15:0]});
      got++;
    end
    check_range(got, 33, 36);
    check(conv_ready, 1'b1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the whole run needs about 0.86 ms; the limit stays under 100,000 cycles.
  initial
  begin
    #950us;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    clk          = 1'b0;
    reset_n      = 1'b0;
    conv_word    = WORD;
    mode_sel     = 2'h0;
    wide_variant = 1'b0;
    mrise        = 0;
    fail_count   = 0;
    num_checks   = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    m0 = mrise;
    repeat (3) @(posedge clk);
    t_self_narrow();
    t_self_wide();
    t_abort();
    t_ext();
    t_async();
    t_fill();
    end_sim();
  end
endmodule

`default_nettype wire
